// [src/cppm_top.sv]
// Power-management control of one copper transceiver port, AXI4-Lite registers
//
// Operation
// - Low power idle is used only at 100 and 1000 Mb/s.
// - Magic-packet wake detection works at 10, 100 and 1000 Mb/s.
// - Wake detection only when wake interrupt enable set; pending bit reports it.
// - A valid magic packet raises the interrupt output and drives the indicator.
// - Packets are compared with the stored station address, with secure option.
// - While searching, special pulses are sent and status reads 00.
// - Looped-back pulses set detection status to 01.
// - No loop-back within the time limit sets detection status to 10.
// - Status 10 clears detect enable, starts auto-negotiation, link bit follows link.
// - Link failure stops auto-negotiation and restarts powered device detection.
// - Setting auto_sleep_enable starts the sleep machine at any time.
// - Low power and wake-up alternate at the sleep period until energy appears.
// - After reset with sleep enabled, the machine starts in low power; sleep enable resets to 0, so it goes normal on the first clock.
// - Forced 10/100 without auto-negotiation: cycle until energy, then stay normal.
// - Auto-negotiation off in normal state: stay normal after link loss.
// - Low power powers down blocks, watches energy, goes normal on energy.
// - Each sleep period is randomised by -80 ms to +60 ms.
// - Wake-up sends up to three pulse bursts on alternating pairs, then low power.
// - Normal state waits the link time-out after link loss before low power.
`timescale 1ns/1ps

module cppm_top
    import cppm_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // AXI4-Lite slave
    input  wire logic [7:0]  i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    input  wire logic [7:0]  i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    // Line-side status pins
    input  wire logic        i_energy_detect,
    input  wire logic        i_link_up,
    input  wire logic        i_flp_loopback,
    // Receive path, same clock
    input  wire logic [1:0]  i_link_speed,
    input  wire logic        i_tx_idle,
    input  wire logic        i_magic_valid,
    input  wire logic [47:0] i_magic_addr,
    input  wire logic        i_magic_password_ok,
    // Power and line control
    output logic             o_power_down,
    output logic             o_flp_burst,
    output logic             o_flp_pair_b,
    output logic             o_pd_flp_send,
    output logic             o_autoneg_run,
    output logic             o_low_power_idle,
    output logic             o_reduced_amplitude_10,
    // Wake indication
    output logic             o_wake_irq,
    output logic             o_wake_led
);

    function automatic logic [MS_W-1:0] step_ms(input logic [1:0] code, input int step);
        step_ms = MS_W'((int'(code) + 1) * step);
    endfunction

    function automatic logic [MS_W-1:0] wake_ms(input logic [1:0] code);
        case (code)
            2'b00:   wake_ms = MS_W'(160);
            2'b01:   wake_ms = MS_W'(400);
            2'b10:   wake_ms = MS_W'(800);
            default: wake_ms = MS_W'(2000);
        endcase
    endfunction

    // Pin synchronisers: energy, link, loopback
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {i_flp_loopback, i_link_up, i_energy_detect};
            sync2_q <= sync1_q;
        end
    end
    logic energy_s, link_s, loop_s;
    assign energy_s = sync2_q[0];
    assign link_s   = sync2_q[1];
    assign loop_s   = sync2_q[2];

    // Millisecond tick and jitter source
    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic [15:0] lfsr_q, lfsr_d;
    logic        ms_tick;
    always_comb begin
        ms_tick    = (tick_cnt_q == 16'(TICK_LEN - 1));
        tick_cnt_d = ms_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        lfsr_d     = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_cnt_q <= 16'h0000;
            lfsr_q     <= LFSR_SEED;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            lfsr_q     <= lfsr_d;
        end
    end

    // Register file and AXI4-Lite slave
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [TMR_W-1:0]  tmr_q, tmr_d;
    logic [47:0]       wake_addr_q, wake_addr_d;
    logic              wake_pend_q, wake_pend_d;
    logic [7:0]        aw_addr_q, aw_addr_d;
    logic              aw_full_q, aw_full_d;
    logic [31:0]       w_data_q, w_data_d;
    logic [3:0]        w_strb_q, w_strb_d;
    logic              w_full_q, w_full_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              rvalid_q, rvalid_d;
    logic [1:0]        rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              pd_self_clear;
    logic              pd_self_set;
    logic              magic_hit;
    logic [31:0]       status_word;
    cppm_sleep_t       slp_q, slp_d;
    logic [1:0]        pd_stat_q, pd_stat_d;
    logic              link_stat_q, link_stat_d;

    assign o_axi_awready = !aw_full_q && !bvalid_q;
    assign o_axi_wready  = !w_full_q && !bvalid_q;
    assign o_axi_arready = !rvalid_q;
    assign o_axi_bvalid  = bvalid_q;
    assign o_axi_bresp   = bresp_q;
    assign o_axi_rvalid  = rvalid_q;
    assign o_axi_rresp   = rresp_q;
    assign o_axi_rdata   = rdata_q;

    // Address match and secure password gate the wake event
    assign magic_hit = i_magic_valid && ctrl_q[CTRL_WAKE_IRQ_EN] && ctrl_q[CTRL_WAKE_EN_BIT]
                     && (i_magic_addr == wake_addr_q)
                     && (!ctrl_q[CTRL_SECURE_EN_BIT] || i_magic_password_ok);

    always_comb begin
        status_word = 32'h0;
        status_word[STAT_STATE_LSB +: 3] = slp_q;
        status_word[STAT_PD_LSB +: 2]    = pd_stat_q;
        status_word[STAT_LINK_BIT]       = link_stat_q;
        status_word[STAT_WAKE_BIT]       = wake_pend_q;
        status_word[STAT_IDLE_BIT]       = o_low_power_idle;
    end

    always_comb begin
        logic       do_wr;
        do_wr       = 1'b0;
        aw_addr_d   = aw_addr_q;
        aw_full_d   = aw_full_q;
        w_data_d    = w_data_q;
        w_strb_d    = w_strb_q;
        w_full_d    = w_full_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        rvalid_d    = rvalid_q;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;
        ctrl_d      = ctrl_q;
        tmr_d       = tmr_q;
        wake_addr_d = wake_addr_q;
        wake_pend_d = wake_pend_q;
        if (i_axi_awvalid && o_axi_awready) begin
            aw_addr_d = i_axi_awaddr;
            aw_full_d = 1'b1;
        end
        if (i_axi_wvalid && o_axi_wready) begin
            w_data_d = i_axi_wdata;
            w_strb_d = i_axi_wstrb;
            w_full_d = 1'b1;
        end
        if (aw_full_q && w_full_q) begin
            do_wr     = 1'b1;
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
        end
        if (bvalid_q && i_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Hardware detection hand-over, software write below takes precedence
        if (pd_self_clear) begin
            ctrl_d[CTRL_PD_EN_BIT] = 1'b0;
        end
        if (do_wr) begin
            case (aw_addr_q)
                OFS_CTRL: begin
                    if (w_strb_q[0]) begin
                        ctrl_d = w_data_q[CTRL_W-1:0];
                    end
                end
                OFS_TIMER: begin
                    if (w_strb_q[0]) begin
                        tmr_d = w_data_q[TMR_W-1:0];
                    end
                end
                OFS_STATUS: begin
                    if (w_strb_q[0] && w_data_q[STAT_WAKE_BIT]) begin
                        wake_pend_d = 1'b0;
                    end
                end
                OFS_WAKE_ADDR_LO: begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb_q[b]) begin
                            wake_addr_d[b*8 +: 8] = w_data_q[b*8 +: 8];
                        end
                    end
                end
                OFS_WAKE_ADDR_HI: begin
                    for (int b = 0; b < 2; b++) begin
                        if (w_strb_q[b]) begin
                            wake_addr_d[32 + b*8 +: 8] = w_data_q[b*8 +: 8];
                        end
                    end
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        // Restart on link failure beats a same-cycle write
        if (pd_self_set) begin
            ctrl_d[CTRL_PD_EN_BIT] = 1'b1;
        end
        // A new wake event beats a same-cycle clear
        if (magic_hit) begin
            wake_pend_d = 1'b1;
        end
        if (rvalid_q && i_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_axi_arvalid && o_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (i_axi_araddr)
                OFS_CTRL:         rdata_d = {24'h0, ctrl_q};
                OFS_TIMER:        rdata_d = {26'h0, tmr_q};
                OFS_STATUS:       rdata_d = status_word;
                OFS_WAKE_ADDR_LO: rdata_d = wake_addr_q[31:0];
                OFS_WAKE_ADDR_HI: rdata_d = {16'h0, wake_addr_q[47:32]};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_addr_q   <= 8'h00;
            aw_full_q   <= 1'b0;
            w_data_q    <= 32'h0;
            w_strb_q    <= 4'h0;
            w_full_q    <= 1'b0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RESP_OKAY;
            rvalid_q    <= 1'b0;
            rresp_q     <= RESP_OKAY;
            rdata_q     <= 32'h0;
            ctrl_q      <= CTRL_RST;
            tmr_q       <= TMR_RST;
            wake_addr_q <= 48'h0;
            wake_pend_q <= 1'b0;
        end else begin
            aw_addr_q   <= aw_addr_d;
            aw_full_q   <= aw_full_d;
            w_data_q    <= w_data_d;
            w_strb_q    <= w_strb_d;
            w_full_q    <= w_full_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            ctrl_q      <= ctrl_d;
            tmr_q       <= tmr_d;
            wake_addr_q <= wake_addr_d;
            wake_pend_q <= wake_pend_d;
        end
    end

    // Automatic sleep machine
    logic [MS_W-1:0] slp_ms_q, slp_ms_d;
    logic [MS_W-1:0] slp_target_q, slp_target_d;
    logic [1:0]      bursts_q, bursts_d;
    logic            pair_b_q, pair_b_d;
    logic            flp_q, flp_d;
    logic            aneg_en, sleep_en;
    assign aneg_en  = ctrl_q[CTRL_ANEG_EN_BIT];
    assign sleep_en = ctrl_q[CTRL_SLEEP_EN_BIT];

    always_comb begin
        logic [7:0] jit;
        logic       enter;
        jit          = (lfsr_q[7:0] > 8'(JITTER_NEG_MS + JITTER_POS_MS))
                     ? lfsr_q[7:0] - 8'(JITTER_NEG_MS + JITTER_POS_MS + 1) : lfsr_q[7:0];
        enter        = 1'b0;
        slp_d        = slp_q;
        slp_target_d = slp_target_q;
        bursts_d     = bursts_q;
        pair_b_d     = pair_b_q;
        flp_d        = 1'b0;
        slp_ms_d     = ms_tick ? slp_ms_q + MS_W'(1) : slp_ms_q;
        case (slp_q)
            SLP_LOW: begin
                if (energy_s) begin
                    slp_d = SLP_NORM;
                end else if (slp_ms_q >= slp_target_q) begin
                    slp_d = SLP_WAKE;
                end
            end
            SLP_WAKE: begin
                if (energy_s) begin
                    slp_d = SLP_NORM;
                end else if (slp_ms_q >= wake_ms(tmr_q[TMR_WAKE_LSB +: 2])) begin
                    slp_d = SLP_LOW;
                end else if (ms_tick && bursts_q < 2'(FLP_BURSTS)
                             && slp_ms_q == MS_W'(int'(bursts_q) * FLP_SPACING_MS)) begin
                    flp_d    = 1'b1;
                    pair_b_d = !pair_b_q;
                    bursts_d = bursts_q + 2'd1;
                end
            end
            SLP_NORM: begin
                if (link_s || energy_s) begin
                    slp_ms_d = '0;
                end else if (aneg_en && slp_ms_q >= step_ms({tmr_q[TMR_LINK_HI],
                             tmr_q[TMR_LINK_LO]}, LINK_STEP_MS)) begin
                    slp_d = SLP_LOW;
                end
            end
            default: slp_d = SLP_NORM;
        endcase
        if (!sleep_en) begin
            slp_d = SLP_NORM;
        end
        enter = (slp_d != slp_q);
        if (enter) begin
            slp_ms_d = '0;
            bursts_d = 2'd0;
            // Base period plus offset, shifted down so it spans -80..+60 ms
            slp_target_d = step_ms(tmr_q[TMR_SLEEP_LSB +: 2], SLEEP_STEP_MS)
                         + MS_W'(jit) - MS_W'(JITTER_NEG_MS);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slp_q        <= SLP_LOW;
            slp_ms_q     <= '0;
            slp_target_q <= MS_W'(2 * SLEEP_STEP_MS);
            bursts_q     <= 2'd0;
            pair_b_q     <= 1'b0;
            flp_q        <= 1'b0;
        end else begin
            slp_q        <= slp_d;
            slp_ms_q     <= slp_ms_d;
            slp_target_q <= slp_target_d;
            bursts_q     <= bursts_d;
            pair_b_q     <= pair_b_d;
            flp_q        <= flp_d;
        end
    end

    // Powered device detection
    cppm_pd_t        pd_q, pd_d;
    logic [MS_W-1:0] pd_ms_q, pd_ms_d;
    always_comb begin
        pd_d          = pd_q;
        pd_stat_d     = pd_stat_q;
        link_stat_d   = link_s;
        pd_ms_d       = ms_tick ? pd_ms_q + MS_W'(1) : pd_ms_q;
        pd_self_clear = 1'b0;
        pd_self_set   = 1'b0;
        case (pd_q)
            PDS_OFF: begin
                if (ctrl_q[CTRL_PD_EN_BIT] && aneg_en) begin
                    pd_d      = PDS_SEARCH;
                    pd_stat_d = PD_SEARCHING;
                end
            end
            PDS_SEARCH: begin
                if (!ctrl_q[CTRL_PD_EN_BIT]) begin
                    pd_d = PDS_OFF;
                end else if (loop_s) begin
                    pd_d      = PDS_FOUND;
                    pd_stat_d = PD_NEEDS_PWR;
                end else if (pd_ms_q >= MS_W'(PD_TIMEOUT_MS)) begin
                    pd_d          = PDS_NEG;
                    pd_stat_d     = PD_TIMED_OUT;
                    pd_self_clear = 1'b1;
                end
            end
            PDS_FOUND: begin
                if (!ctrl_q[CTRL_PD_EN_BIT]) begin
                    pd_d = PDS_OFF;
                end else if (link_s) begin
                    pd_d = PDS_NEG;
                end
            end
            PDS_NEG: begin
                if (link_stat_q && !link_s) begin
                    pd_d        = PDS_SEARCH;
                    pd_stat_d   = PD_SEARCHING;
                    pd_self_set = 1'b1;
                end
            end
            default: pd_d = PDS_OFF;
        endcase
        if (pd_d != pd_q) begin
            pd_ms_d = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pd_q        <= PDS_OFF;
            pd_ms_q     <= '0;
            pd_stat_q   <= PD_SEARCHING;
            link_stat_q <= 1'b0;
        end else begin
            pd_q        <= pd_d;
            pd_ms_q     <= pd_ms_d;
            pd_stat_q   <= pd_stat_d;
            link_stat_q <= link_stat_d;
        end
    end

    // Output stage
    logic [7:0] out_q, out_d;
    always_comb begin
        out_d    = 8'h00;
        out_d[0] = (slp_q == SLP_LOW) || ctrl_q[CTRL_PWR_OFF_BIT];
        out_d[1] = flp_d;
        out_d[2] = pair_b_d;
        out_d[3] = (pd_q == PDS_SEARCH);
        out_d[4] = (pd_q == PDS_NEG) || (pd_q == PDS_OFF && aneg_en);
        out_d[5] = link_s && i_tx_idle && ((i_link_speed == SPEED_1000)
                 || (i_link_speed == SPEED_100 && !ctrl_q[CTRL_IDLE_RX_DIS]));
        out_d[6] = ctrl_q[CTRL_IDLE_RX_DIS] && (i_link_speed == SPEED_10);
        out_d[7] = wake_pend_d;
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_q <= 8'h00;
        end else begin
            out_q <= out_d;
        end
    end
    assign o_power_down           = out_q[0];
    assign o_flp_burst            = out_q[1];
    assign o_flp_pair_b           = out_q[2];
    assign o_pd_flp_send          = out_q[3];
    assign o_autoneg_run          = out_q[4];
    assign o_low_power_idle       = out_q[5];
    assign o_reduced_amplitude_10 = out_q[6];
    assign o_wake_irq             = out_q[7] && ctrl_q[CTRL_WAKE_IRQ_EN];
    assign o_wake_led             = out_q[7];

endmodule // cppm_top

// [src/cppm_pkg.sv]
// Constants and types shared by the copper power-management block
package cppm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_TIMER        = 8'h04;
    localparam logic [7:0] OFS_STATUS       = 8'h08;
    localparam logic [7:0] OFS_WAKE_ADDR_LO = 8'h0C;
    localparam logic [7:0] OFS_WAKE_ADDR_HI = 8'h10;

    // Control register fields
    localparam int CTRL_SLEEP_EN_BIT   = 0;
    localparam int CTRL_ANEG_EN_BIT    = 1;
    localparam int CTRL_IDLE_RX_DIS    = 2;
    localparam int CTRL_PWR_OFF_BIT    = 3;
    localparam int CTRL_PD_EN_BIT      = 4;
    localparam int CTRL_WAKE_IRQ_EN    = 5;
    localparam int CTRL_WAKE_EN_BIT    = 6;
    localparam int CTRL_SECURE_EN_BIT  = 7;
    localparam int CTRL_W              = 8;
    localparam logic [7:0] CTRL_RST    = 8'h02;

    // Timer register fields
    localparam int TMR_SLEEP_LSB = 0;
    localparam int TMR_WAKE_LSB  = 2;
    localparam int TMR_LINK_LO   = 4;
    localparam int TMR_LINK_HI   = 5;
    localparam int TMR_W         = 6;
    localparam logic [5:0] TMR_RST = 6'h01;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PD_LSB    = 4;
    localparam int STAT_LINK_BIT  = 6;
    localparam int STAT_WAKE_BIT  = 7;
    localparam int STAT_IDLE_BIT  = 8;

    // Detection status codes
    localparam logic [1:0] PD_SEARCHING = 2'b00;
    localparam logic [1:0] PD_NEEDS_PWR = 2'b01;
    localparam logic [1:0] PD_TIMED_OUT = 2'b10;

    // Link speed codes
    localparam logic [1:0] SPEED_10   = 2'b00;
    localparam logic [1:0] SPEED_100  = 2'b01;
    localparam logic [1:0] SPEED_1000 = 2'b10;

    // Timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MS_NS           = 1000000;
    localparam int TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int MS_W            = 13;
    localparam int SLEEP_STEP_MS   = 1000;
    localparam int LINK_STEP_MS    = 1000;
    localparam int JITTER_NEG_MS   = 80;
    localparam int JITTER_POS_MS   = 60;
    localparam int FLP_SPACING_MS  = 16;
    localparam int FLP_BURSTS      = 3;
    localparam int PD_TIMEOUT_MS   = 500;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        SLP_LOW  = 3'b001,
        SLP_WAKE = 3'b010,
        SLP_NORM = 3'b100
    } cppm_sleep_t;

    typedef enum logic [3:0] {
        PDS_OFF    = 4'b0001,
        PDS_SEARCH = 4'b0010,
        PDS_FOUND  = 4'b0100,
        PDS_NEG    = 4'b1000
    } cppm_pd_t;

endpackage

// [test/cppm_top_asserts.sv]
// Port checker for the copper power-management block
`timescale 1ns/1ps

module cppm_top_chk
    import cppm_pkg::*;
(
    input wire logic        i_ref_clk, i_rstn, i_axi_bready, i_axi_rready, i_energy_detect,
    input wire logic [1:0]  i_link_speed,
    input wire logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_rvalid,
    input wire logic [31:0] o_axi_rdata,
    input wire logic        o_low_power_idle, o_reduced_amplitude_10, o_pd_flp_send,
    input wire logic        o_autoneg_run, o_wake_irq, o_wake_led, o_power_down
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    chk_ten_amp: assert property (
        o_reduced_amplitude_10 |-> $past(i_link_speed) == SPEED_10) else $error("amp off 10M");
    chk_idle_fast: assert property (
        o_low_power_idle |-> $past(i_link_speed) != SPEED_10) else $error("idle at 10M");
    chk_pd_split: assert property (!(o_pd_flp_send && o_autoneg_run))
        else $error("search with autoneg");
    chk_irq_led: assert property (o_wake_irq |-> o_wake_led) else $error("irq no led");
    chk_energy_on: assert property (
        $rose(i_energy_detect) |-> ##[1:6] !o_power_down) else $error("no wake on energy");
    chk_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid)
        else $error("bvalid dropped");
    chk_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=>
        o_axi_rvalid && $stable(o_axi_rdata)) else $error("read answer dropped");
    chk_aw_block: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("write open during answer");
endmodule // cppm_top_chk

bind cppm_top cppm_top_chk cppm_top_chk_i (.*);

// [test/cppm_line_model.sv]
// Line-side model of the remote link partner
`timescale 1ns/1ps

module cppm_line_model (
    // Clock, bench commands and transceiver outputs
    input  wire logic i_ref_clk, i_plug, i_loop, i_flp_send, i_an,
    // Pins seen by the transceiver
    output logic      o_energy, o_link, o_loop
);
    always_ff @(posedge i_ref_clk) begin
        o_energy <= i_plug;
        o_link   <= i_plug && i_an;
        o_loop   <= i_loop && i_flp_send;
    end
endmodule // cppm_line_model

// [test/test_cppm_top.sv]
// Bench for the copper power-management block
`timescale 1ns/1ps

module test_cppm_top;
    import cppm_pkg::*;
    logic        i_ref_clk = '0, i_rstn = '0, i_axi_awvalid = '0, i_axi_wvalid = '0;
    logic        i_axi_bready = '0, i_axi_arvalid = '0, i_axi_rready = '0, i_tx_idle = '0;
    logic        i_magic_valid = '0, i_magic_password_ok = '0, plug = '0, loop = '0;
    logic        i_energy_detect, i_link_up, i_flp_loopback, o_axi_awready, o_axi_wready;
    logic [7:0]  i_axi_awaddr = '0, i_axi_araddr = '0;
    logic [31:0] i_axi_wdata = '0, o_axi_rdata;
    logic [3:0]  i_axi_wstrb = 4'hF;
    logic [1:0]  i_link_speed = SPEED_10, o_axi_bresp, o_axi_rresp;
    logic [47:0] i_magic_addr = '0;
    logic        o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_power_down, o_flp_burst;
    logic        o_flp_pair_b, o_pd_flp_send, o_autoneg_run, o_low_power_idle;
    logic        o_reduced_amplitude_10, o_wake_irq, o_wake_led;
    int          bad_count = 0, cmp_count = 0;

    cppm_top #(.TICK_LEN(10)) cppm_top_i (.*);
    cppm_line_model cppm_line_model_i (.i_ref_clk, .i_plug(plug), .i_loop(loop),
        .i_flp_send(o_pd_flp_send), .i_an(o_autoneg_run), .o_energy(i_energy_detect),
        .o_link(i_link_up), .o_loop(i_flp_loopback));
    initial forever #12.5 i_ref_clk = ~i_ref_clk;

    task automatic chk(input string s, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s exp %h got %h", s, e, g);
            bad_count++;
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One AXI4-Lite access, read when w is low
    task automatic acc(input logic w, logic [7:0] a, logic [31:0] d, logic [1:0] e);
        int   n;
        logic ta, tw, tr;
        @(posedge i_ref_clk);
        i_axi_awaddr <= a;
        i_axi_araddr <= a;
        i_axi_wdata <= d;
        {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= {3{w}};
        {i_axi_arvalid, i_axi_rready} <= {2{!w}};
        for (n = 0; n < 40; n++) begin
            @(negedge i_ref_clk);
            if (o_axi_bvalid || o_axi_rvalid) break;
            {ta, tw, tr} = {o_axi_awready, o_axi_wready, o_axi_arready};
            @(posedge i_ref_clk);
            if (ta) i_axi_awvalid <= 1'b0;
            if (tw) i_axi_wvalid <= 1'b0;
            if (tr) i_axi_arvalid <= 1'b0;
        end
        chk("answer", 32'h1, 32'(n < 40));
        if (n == 40) report_and_stop;
        chk("resp", 32'(e), 32'(w ? o_axi_bresp : o_axi_rresp));
        if (!w) chk("rdata", d, o_axi_rdata);
        @(posedge i_ref_clk);
        {i_axi_bready, i_axi_rready} <= 2'h0;
    endtask

    // Bounded wait: 0 sleep, 1 awake, 2 burst, 3 search off, 4 search on
    task automatic wt(input int k, int lim);
        int       n;
        logic [4:0] s;
        for (n = 0; n < lim; n++) begin
            @(negedge i_ref_clk);
            s = {o_pd_flp_send, !o_pd_flp_send, o_flp_burst, !o_power_down, o_power_down};
            if (s[k] === 1'b1) break;
        end
        chk("wait", 32'h1, 32'(n < lim));
        if (n == lim) report_and_stop;
    endtask

    task automatic magic(input logic [47:0] a, logic e);
        @(posedge i_ref_clk);
        i_magic_addr <= a;
        i_magic_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_magic_valid <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk("wake", 32'({2{e}}), 32'({o_wake_irq, o_wake_led}));
    endtask

    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        acc(0, OFS_CTRL, 32'h02, RESP_OKAY);
        acc(0, 8'h14, 32'h0, RESP_SLVERR);
        acc(1, OFS_CTRL, 32'h03, RESP_OKAY);
        wt(0, 12000);
        acc(0, OFS_STATUS, 32'h01, RESP_OKAY);
        wt(2, 22000);
        chk("pair", 32'h1, 32'(o_flp_pair_b));
        acc(0, OFS_STATUS, 32'h02, RESP_OKAY);
        acc(1, OFS_CTRL, 32'h02, RESP_OKAY);
        acc(0, OFS_STATUS, 32'h04, RESP_OKAY);
        acc(1, OFS_CTRL, 32'h03, RESP_OKAY);
        wt(0, 12000);
        plug <= 1'b1;
        wt(1, 20);
        plug <= 1'b0;
        acc(1, OFS_CTRL, 32'h12, RESP_OKAY);
        acc(0, OFS_STATUS, 32'h04, RESP_OKAY);
        wt(3, 6000);
        acc(0, OFS_STATUS, 32'h24, RESP_OKAY);
        acc(0, OFS_CTRL, 32'h02, RESP_OKAY);
        acc(1, OFS_CTRL, 32'h12, RESP_OKAY);
        plug <= 1'b1;
        i_tx_idle <= 1'b1;
        i_link_speed <= SPEED_1000;
        repeat (6) @(posedge i_ref_clk);
        chk("idle", 32'h1, 32'(o_low_power_idle));
        plug <= 1'b0;
        loop <= 1'b1;
        i_link_speed <= SPEED_10;
        wt(4, 20);
        wt(3, 50);
        acc(0, OFS_STATUS, 32'h14, RESP_OKAY);
        loop <= 1'b0;
        acc(1, OFS_WAKE_ADDR_LO, 32'h33445566, RESP_OKAY);
        acc(1, OFS_WAKE_ADDR_HI, 32'h1122, RESP_OKAY);
        acc(1, OFS_CTRL, 32'h66, RESP_OKAY);
        @(negedge i_ref_clk);
        chk("amp10", 32'h1, 32'(o_reduced_amplitude_10));
        magic(48'h112233445566, 1'b1);
        acc(1, OFS_STATUS, 32'h80, RESP_OKAY);
        magic(48'h112233445567, 1'b0);
        report_and_stop;
    end
endmodule // test_cppm_top
